// ---- hdl/itr_params.svh ----
`ifndef ITR_PARAMS_SVH
`define ITR_PARAMS_SVH
// register byte offsets
`define ITR_ADR_DEVCTL    8'h00
`define ITR_ADR_ROUTE     8'h04
`define ITR_ADR_SECFN     8'h08
`define ITR_ADR_MISC      8'h0c
`define ITR_ADR_SRC       8'h10
`define ITR_ADR_STATUS    8'h14
`define ITR_ADR_CLEAR     8'h18
`define ITR_ADR_ENABLE    8'h1c
// reset values
`define ITR_RST_DEVCTL    2'h0
`define ITR_RST_ROUTE     32'h0000_0000
`define ITR_RST_SECFN     8'h00
`define ITR_RST_MISC      2'h0
// misc control field positions
`define ITR_MISC_GP3_INTA 0
`define ITR_MISC_RI_PME   1
// width in bits of a secondary role code
`define ITR_ROLE_W        3
// status bit positions
`define ITR_ST_INTA       0
`define ITR_ST_INTB       1
`define ITR_ST_ILLEGAL    2
`define ITR_ST_W          3
// serial stream frame length in slots
`define ITR_SER_SLOTS     5'h14
`define ITR_SER_INTA_SLOT 5'h10
`define ITR_SER_INTB_SLOT 5'h11
`endif

// ---- hdl/itr_pkg.sv ----
package itr_pkg;
  // interrupt signalling mode
  typedef enum logic [1:0] {
    ITR_MODE_SER_SER = 2'b00,  // serial legacy, serial pci
    ITR_MODE_SER_PAR = 2'b01,  // serial legacy, parallel pci
    ITR_MODE_PAR_PAR = 2'b10,  // routed legacy, parallel pci
    ITR_MODE_PAR_PCI = 2'b11   // parallel pci only
  } itr_mode_e;
  // secondary roles of a routed output
  typedef enum logic [2:0] {
    ITR_ROLE_IRQ   = 3'b000,
    ITR_ROLE_INTB  = 3'b001,
    ITR_ROLE_DMA   = 3'b010,
    ITR_ROLE_RING  = 3'b011,
    ITR_ROLE_VIDEO = 3'b100
  } itr_role_e;
  // serial frame states
  typedef enum logic [1:0] {
    ITR_SER_IDLE  = 2'b00,
    ITR_SER_START = 2'b01,
    ITR_SER_SLOT  = 2'b10,
    ITR_SER_STOP  = 2'b11
  } itr_ser_e;
  // interrupt sources gathered together
  typedef struct packed {
    logic        inta;
    logic        intb;
    logic [15:0] irq;
  } itr_src_s;
  // secondary function inputs
  typedef struct packed {
    logic dma_grant;
    logic dma_request;
    logic ring;
    logic video;
  } itr_sec_s;
endpackage : itr_pkg

// ---- hdl/itr_route.sv ----
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "itr_params.svh"
module itr_route #(
  parameter int N_OUT = 8  // number of routed outputs
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // wishbone slave
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [3:0]           i_wb_sel,
  input  wire logic [31:0]          i_wb_dat,
  output logic      [31:0]          o_wb_dat,
  output logic                      o_wb_ack,
  // interrupt sources and secondary functions
  input  wire itr_pkg::itr_src_s    i_src,
  input  wire itr_pkg::itr_sec_s    i_sec,
  input  wire logic                 i_pme,
  // general purpose pin three
  input  wire logic                 i_general_purpose_pin_three,
  output logic                      o_general_purpose_pin_three,
  output logic                      o_general_purpose_pin_three_oe_n,
  // serial interrupt line
  input  wire logic                 i_serial_interrupt_line,
  output logic                      o_serial_interrupt_line,
  output logic                      o_serial_interrupt_line_oe_n,
  // routed outputs (index 6 doubles as dma grant, 7 as dma request)
  output logic      [N_OUT-1:0]     o_routed_interrupt_out,
  // ring indicate output
  output logic                      o_ring_indicate_output,
  // interrupt to system
  output logic                      o_irq
);

  // control registers
  itr_pkg::itr_mode_e   mode_r;          // signalling mode
  logic [4*N_OUT-1:0]   route_r;         // 4-bit irq number per output
  logic [N_OUT-1:0]     out_en_r;        // routed output enables
  logic [3*N_OUT-1:0]   role_r;          // role code per output
  logic [1:0]           misc_r;          // gp3 inta select, ring pme select
  logic [`ITR_ST_W-1:0] status_r;        // sticky events
  logic [`ITR_ST_W-1:0] enable_r;        // event enables
  logic [31:0]          rd_nxt;          // read mux
  logic                 ack_r;           // ack flop
  logic [2:0]           gp3_sync_r;      // pin three synchroniser
  logic                 gp3_in_r;        // filtered pin three level
  logic [2:0]           ser_sync_r;      // serial line synchroniser
  logic                 ser_in_r;        // filtered serial line level
  logic                 wr_stb;          // write accepted this cycle
  logic                 rd_stb;          // read accepted this cycle
  logic [`ITR_ST_W-1:0] ev;              // events this cycle
  logic [`ITR_ST_W-1:0] clr;             // clears this cycle

  // bus request accepted once, ack for one cycle
  assign wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
  assign rd_stb = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r;

  // byte lane merge of a 32-bit write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // pci lines that are live in a parallel mode
  function automatic logic par_pci(input itr_pkg::itr_mode_e m);
    return (m != itr_pkg::ITR_MODE_SER_SER);
  endfunction : par_pci

  // ack generation
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (wr_stb || rd_stb);
    end
  end

  // mode and misc registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_r <= itr_pkg::itr_mode_e'(`ITR_RST_DEVCTL);
      misc_r <= `ITR_RST_MISC;
    end else if (wr_stb && i_wb_sel[0]) begin
      if (i_wb_adr == `ITR_ADR_DEVCTL) begin
        mode_r <= itr_pkg::itr_mode_e'(i_wb_dat[1:0]);
      end
      if (i_wb_adr == `ITR_ADR_MISC) begin
        misc_r <= i_wb_dat[1:0];
      end
    end
  end

  // routing, enable and role registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      route_r  <= `ITR_RST_ROUTE;
      out_en_r <= `ITR_RST_SECFN;
      role_r   <= '0;
    end else if (wr_stb) begin
      if (i_wb_adr == `ITR_ADR_ROUTE) begin
        route_r <= lane_merge(route_r, i_wb_dat, i_wb_sel);
      end
      if (i_wb_adr == `ITR_ADR_SECFN) begin
        out_en_r <= i_wb_sel[0] ? i_wb_dat[7:0] : out_en_r;
        // role bytes sit in lanes one to three
        for (int b = 1; b < 4; b++) begin
          if (i_wb_sel[b]) begin
            role_r[8*(b-1) +: 8] <= i_wb_dat[8*b +: 8];
          end
        end
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      enable_r <= '0;
    end else if (wr_stb && i_wb_sel[0] && i_wb_adr == `ITR_ADR_ENABLE) begin
      enable_r <= i_wb_dat[`ITR_ST_W-1:0];
    end
  end

  // events: pci lines going pending, output enabled in wrong mode
  assign ev[`ITR_ST_INTA]    = i_src.inta;
  assign ev[`ITR_ST_INTB]    = i_src.intb;
  assign ev[`ITR_ST_ILLEGAL] = (|out_en_r) &&
                               (mode_r != itr_pkg::ITR_MODE_PAR_PAR);
  assign clr = (wr_stb && i_wb_sel[0] && i_wb_adr == `ITR_ADR_CLEAR) ?
               i_wb_dat[`ITR_ST_W-1:0] : '0;

  // sticky status, a set beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clr) | ev;
    end
  end

  // interrupt output
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((status_r & ~clr) | ev) & enable_r);
    end
  end

  // read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (i_wb_adr)
      `ITR_ADR_DEVCTL: rd_nxt[1:0] = mode_r;
      `ITR_ADR_ROUTE:  rd_nxt = route_r;
      `ITR_ADR_SECFN:  rd_nxt = {role_r, out_en_r};
      `ITR_ADR_MISC:   rd_nxt[1:0] = misc_r;
      `ITR_ADR_SRC:    rd_nxt = {12'h000, ser_in_r, gp3_in_r, i_src};
      `ITR_ADR_STATUS: rd_nxt[`ITR_ST_W-1:0] = status_r;
      `ITR_ADR_ENABLE: rd_nxt[`ITR_ST_W-1:0] = enable_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (rd_stb) begin
      o_wb_dat <= rd_nxt;
    end
  end

  // pin synchronisers, level taken when stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gp3_sync_r <= 3'h0;
      ser_sync_r <= 3'h7;
      gp3_in_r   <= 1'b0;
      ser_in_r   <= 1'b1;
    end else begin
      gp3_sync_r <= {gp3_sync_r[1:0], i_general_purpose_pin_three};
      ser_sync_r <= {ser_sync_r[1:0], i_serial_interrupt_line};
      if (gp3_sync_r[1] == gp3_sync_r[2]) begin
        gp3_in_r <= gp3_sync_r[2];
      end
      if (ser_sync_r[1] == ser_sync_r[2]) begin
        ser_in_r <= ser_sync_r[2];
      end
    end
  end

  // pin three: input after reset, inta open drain when chosen
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_general_purpose_pin_three      <= 1'b0;
      o_general_purpose_pin_three_oe_n <= 1'b1;
    end else begin
      o_general_purpose_pin_three <= 1'b0;
      o_general_purpose_pin_three_oe_n <=
        !(misc_r[`ITR_MISC_GP3_INTA] && par_pci(mode_r) && i_src.inta);
    end
  end

  // serial frame: start, one slot per irq and pci line, stop
  itr_pkg::itr_ser_e ser_st_r;
  logic [4:0]        slot_r;
  logic              slot_bit;
  always_comb begin
    if (slot_r == `ITR_SER_INTA_SLOT) begin
      slot_bit = (mode_r == itr_pkg::ITR_MODE_SER_SER) && i_src.inta;
    end else if (slot_r == `ITR_SER_INTB_SLOT) begin
      slot_bit = (mode_r == itr_pkg::ITR_MODE_SER_SER) && i_src.intb;
    end else if (slot_r[4]) begin
      // spare slots past the pci pair stay quiet, no irq aliasing
      slot_bit = 1'b0;
    end else begin
      slot_bit = i_src.irq[slot_r[3:0]];
    end
  end

  // serial frame sequencer, runs while a serial legacy mode holds
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ser_st_r <= itr_pkg::ITR_SER_IDLE;
      slot_r   <= 5'h00;
    end else begin
      case (ser_st_r)
        itr_pkg::ITR_SER_IDLE: begin
          slot_r <= 5'h00;
          if (!par_pci(mode_r) || mode_r == itr_pkg::ITR_MODE_SER_PAR) begin
            ser_st_r <= itr_pkg::ITR_SER_START;
          end
        end
        itr_pkg::ITR_SER_START: ser_st_r <= itr_pkg::ITR_SER_SLOT;
        itr_pkg::ITR_SER_SLOT: begin
          slot_r <= slot_r + 5'h01;
          if (slot_r == `ITR_SER_SLOTS - 5'h01) begin
            ser_st_r <= itr_pkg::ITR_SER_STOP;
          end
        end
        itr_pkg::ITR_SER_STOP: ser_st_r <= itr_pkg::ITR_SER_IDLE;
        default: ser_st_r <= itr_pkg::ITR_SER_IDLE;
      endcase
    end
  end

  // serial line: frame drive low for start and active slots, else intb
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_serial_interrupt_line      <= 1'b0;
      o_serial_interrupt_line_oe_n <= 1'b1;
    end else begin
      o_serial_interrupt_line <= 1'b0;
      if (mode_r == itr_pkg::ITR_MODE_PAR_PAR || mode_r == itr_pkg::ITR_MODE_PAR_PCI) begin
        o_serial_interrupt_line_oe_n <= !i_src.intb;
      end else begin
        o_serial_interrupt_line_oe_n <= !((ser_st_r == itr_pkg::ITR_SER_START) ||
                                          (ser_st_r == itr_pkg::ITR_SER_SLOT && slot_bit));
      end
    end
  end

  // routed outputs: enabled irq beats dma on six and seven
  logic [N_OUT-1:0] rout_nxt;
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      logic [2:0] role;
      logic       irq_v;
      logic       dma_v;
      assign role  = role_r[3*g +: 3];
      assign irq_v = i_src.irq[route_r[4*g +: 4]] && (route_r[4*g +: 4] != 4'h0);
      assign dma_v = (g == 6) ? i_sec.dma_grant : i_sec.dma_request;
      always_comb begin
        case (itr_pkg::itr_role_e'(role))
          itr_pkg::ITR_ROLE_INTB:  rout_nxt[g] = !i_src.intb;
          itr_pkg::ITR_ROLE_DMA:   rout_nxt[g] = dma_v;
          itr_pkg::ITR_ROLE_RING:  rout_nxt[g] = i_sec.ring;
          itr_pkg::ITR_ROLE_VIDEO: rout_nxt[g] = i_sec.video;
          default: begin
            if (out_en_r[g]) begin
              rout_nxt[g] = irq_v;
            end else begin
              rout_nxt[g] = (g >= 6) ? dma_v : 1'b0;
            end
          end
        endcase
      end
    end
  endgenerate

  // routed output flops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_routed_interrupt_out <= '0;
    end else begin
      o_routed_interrupt_out <= rout_nxt;
    end
  end

  // ring indicate output: card ring or power event
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ring_indicate_output <= 1'b0;
    end else begin
      o_ring_indicate_output <= misc_r[`ITR_MISC_RI_PME] ? i_pme : i_sec.ring;
    end
  end

  assign o_wb_ack = ack_r;

  // checks
  sequence s_wr_misc;
    wr_stb && i_wb_sel[0] && i_wb_adr == `ITR_ADR_MISC;
  endsequence
  gp3_reset_input_a: assert property (@(posedge i_clk) $fell(i_sys_rst) |->
    o_general_purpose_pin_three_oe_n) else $error("pin three driven after reset");
  gp3_inta_drive_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (misc_r[0] && par_pci(mode_r) && i_src.inta) |=> !o_general_purpose_pin_three_oe_n)
    else $error("inta not on pin three");
  ser_intb_par_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_r[1] && i_src.intb) |=> !o_serial_interrupt_line_oe_n)
    else $error("intb not on serial pin");
  ser_start_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!mode_r[1] && ser_st_r == itr_pkg::ITR_SER_START) |=> !o_serial_interrupt_line_oe_n)
    else $error("no start pulse");
  ser_pci_slot_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_r == itr_pkg::ITR_MODE_SER_PAR && ser_st_r == itr_pkg::ITR_SER_SLOT &&
     slot_r == `ITR_SER_INTA_SLOT) |=> o_serial_interrupt_line_oe_n)
    else $error("pci slot in parallel pci mode");
  route_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (role_r[2:0] == 3'h0 && out_en_r[0] && route_r[3:0] != 4'h0)
    |=> o_routed_interrupt_out[0] == $past(i_src.irq[route_r[3:0]]))
    else $error("routed irq wrong");
  sec_ring_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (role_r[2:0] == 3'h3) |=> o_routed_interrupt_out[0] == $past(i_sec.ring))
    else $error("secondary role not carried");
  dma_grant_ovr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (role_r[20:18] == 3'h0 && out_en_r[6] && !i_src.irq[route_r[27:24]])
    |=> !o_routed_interrupt_out[6]) else $error("grant leaked");
  dma_req_ovr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (role_r[23:21] == 3'h0 && out_en_r[7] && !i_src.irq[route_r[31:28]])
    |=> !o_routed_interrupt_out[7]) else $error("request leaked");
  ring_pme_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_wr_misc ##1 misc_r[1] |=> o_ring_indicate_output == $past(i_pme))
    else $error("ring output source wrong");
  intb_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_r[1] && !i_src.intb) |=> o_serial_interrupt_line_oe_n)
    else $error("intb not released");

endmodule : itr_route

// ---- test/itr_host_model.sv ----
`timescale 1ns/10ps
// host side model: pull-ups on the shared lines, decodes active-low lines
module itr_host_model (
  // clock
  input  wire logic        i_clk,
  // device pins
  input  wire logic        i_gp3,
  input  wire logic        i_gp3_oe_n,
  input  wire logic        i_ser,
  input  wire logic        i_ser_oe_n,
  // clears the low-cycle counter
  input  wire logic        i_cnt_clr,
  // resolved lines and what the host sees
  output logic             o_gp3_line,
  output logic             o_ser_line,
  output logic             o_inta_seen,
  output logic             o_intb_seen,
  output logic [15:0]      o_low_cnt
);
  // a released line floats up to the pull-up level
  assign o_gp3_line  = i_gp3_oe_n ? 1'b1 : i_gp3;
  assign o_ser_line  = i_ser_oe_n ? 1'b1 : i_ser;
  // pci interrupts are asserted low
  assign o_inta_seen = ~o_gp3_line;
  assign o_intb_seen = ~o_ser_line;
  // counts cycles the serial stream is held low
  always_ff @(posedge i_clk) begin
    if (i_cnt_clr) begin
      o_low_cnt <= 16'h0000;
    end else if (!o_ser_line) begin
      o_low_cnt <= o_low_cnt + 16'h0001;
    end
  end
endmodule : itr_host_model

// ---- test/test_interrupt_terminal_routing.sv ----
`timescale 1ns/10ps
`include "itr_params.svh"
// register-level bench for the interrupt routing block
module test_interrupt_terminal_routing;
  logic               i_clk;        // 200 mhz clock
  logic               i_sys_rst;    // sync reset
  logic               cyc, stb, we; // wishbone request
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, q;
  logic               ack;
  itr_pkg::itr_src_s  src;          // interrupt sources
  itr_pkg::itr_sec_s  sec;          // secondary inputs
  logic               pme, cnt_clr;
  logic               gp3, gp3_oe_n, ser, ser_oe_n, gp3_ln, ser_ln, inta_s, intb_s, ring, irq;
  logic [7:0]         rout, exp8;
  logic [15:0]        lc [4];       // serial low counts
  logic [31:0]        rt;
  int                 n_errors, checks, cyc_cnt;
  logic [7:0]         rst_adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c, 8'h20};
  logic [2:0]         roles [3] = '{3'h1, 3'h3, 3'h4};

  // clock generator
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  itr_route itr_route_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_src(src), .i_sec(sec), .i_pme(pme),
    .i_general_purpose_pin_three(gp3_ln), .o_general_purpose_pin_three(gp3),
    .o_general_purpose_pin_three_oe_n(gp3_oe_n), .i_serial_interrupt_line(ser_ln),
    .o_serial_interrupt_line(ser), .o_serial_interrupt_line_oe_n(ser_oe_n),
    .o_routed_interrupt_out(rout), .o_ring_indicate_output(ring), .o_irq(irq));

  itr_host_model itr_host_model_i (.i_clk(i_clk), .i_gp3(gp3), .i_gp3_oe_n(gp3_oe_n),
    .i_ser(ser), .i_ser_oe_n(ser_oe_n), .i_cnt_clr(cnt_clr), .o_gp3_line(gp3_ln),
    .o_ser_line(ser_ln), .o_inta_seen(inta_s), .o_intb_seen(intb_s), .o_low_cnt());

  // prints the counts and the verdict, then stops
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // compares a vector result
  task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  // compares a single-bit result
  task automatic chk_b(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_errors++;
      $display("MISMATCH ack expected 1 seen 0");
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clk);
  endtask : wb

  // lets registered outputs follow their inputs
  task automatic settle();
    repeat (4) @(posedge i_clk);
  endtask : settle

  // counts serial low cycles over 47 cycles, one more than two frames of 23 cycles
  task automatic ser_count(input int k);
    cnt_clr <= 1'b1;
    @(posedge i_clk);
    cnt_clr <= 1'b0;
    repeat (47) @(posedge i_clk);
    lc[k] = itr_host_model_i.o_low_cnt;
  endtask : ser_count

  // cuts a hang short
  always @(posedge i_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    {cyc, stb, we, adr, wdat, src, sec, pme, cnt_clr, n_errors, checks, cyc_cnt} = '0;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    // reset values, unmapped address reads zero
    foreach (rst_adr[i]) begin
      wb(1'b0, rst_adr[i], 32'h0);
      chk_v("reset read", 32'h0, q);
    end
    // pin three stays an input until reconfigured
    wb(1'b1, `ITR_ADR_DEVCTL, 32'h2);
    src.inta <= 1'b1;
    settle();
    chk_b("gp3 after reset", 1'b0, inta_s);
    wb(1'b1, `ITR_ADR_MISC, 32'h1);
    settle();
    chk_b("gp3 inta", 1'b1, inta_s);
    src.inta <= 1'b0;
    settle();
    chk_b("gp3 released", 1'b0, inta_s);
    // intb on the serial pin in a parallel mode
    src.intb <= 1'b1;
    settle();
    chk_b("ser intb", 1'b1, intb_s);
    src.intb <= 1'b0;
    settle();
    chk_b("ser intb off", 1'b0, intb_s);
    // sticky status, enable, masking and clearing
    wb(1'b1, `ITR_ADR_CLEAR, 32'h7);
    wb(1'b1, `ITR_ADR_ENABLE, 32'h1);
    src.inta <= 1'b1;
    settle();
    src.inta <= 1'b0;
    settle();
    wb(1'b0, `ITR_ADR_STATUS, 32'h0);
    chk_v("status sticky", 32'h1, q);
    chk_b("irq high", 1'b1, irq);
    wb(1'b1, `ITR_ADR_ENABLE, 32'h0);
    settle();
    chk_b("irq masked", 1'b0, irq);
    wb(1'b1, `ITR_ADR_CLEAR, 32'h1);
    wb(1'b0, `ITR_ADR_STATUS, 32'h0);
    chk_v("status cleared", 32'h0, q);
    // enabling routed outputs in a serial mode is flagged
    wb(1'b1, `ITR_ADR_DEVCTL, 32'h0);
    wb(1'b1, `ITR_ADR_SECFN, 32'h1);
    wb(1'b0, `ITR_ADR_STATUS, 32'h0);
    chk_v("bad order flag", 32'h4, q);
    wb(1'b1, `ITR_ADR_SECFN, 32'h0);
    wb(1'b1, `ITR_ADR_CLEAR, 32'h4);
    // mode, then routing, then enables; irq levels 1 to 15 reached
    wb(1'b1, `ITR_ADR_DEVCTL, 32'h2);
    for (int b = 0; b < 2; b++) begin
      for (int g = 0; g < 8; g++) rt[4*g+:4] = 4'(g + 1 + 7 * b);
      wb(1'b1, `ITR_ADR_ROUTE, rt);
      wb(1'b1, `ITR_ADR_SECFN, 32'hff);
      for (int n = 1; n < 16; n++) begin
        src.irq <= 16'h1 << n;
        settle();
        for (int g = 0; g < 8; g++) exp8[g] = (g + 1 + 7 * b == n);
        chk_v("routed", {24'h0, exp8}, {24'h0, rout});
      end
    end
    // secondary roles replace routing on output zero
    wb(1'b1, `ITR_ADR_ROUTE, 32'h1);
    src.irq <= 16'h0002;
    foreach (roles[r]) begin
      wb(1'b1, `ITR_ADR_SECFN, {21'h0, roles[r], 8'h01});
      for (int v = 0; v < 2; v++) begin
        sec.ring <= v[0];
        sec.video <= v[0];
        src.intb <= ~v[0];
        settle();
        chk_b("role out0", v[0], rout[0]);
      end
    end
    // outputs six and seven over the dma handshake
    src <= '0;
    wb(1'b1, `ITR_ADR_SECFN, 32'h0);
    sec.dma_grant <= 1'b1;
    settle();
    chk_v("dma pass", 32'h1, {30'h0, rout[7:6]});
    sec.dma_request <= 1'b1;
    wb(1'b1, `ITR_ADR_ROUTE, 32'h5500_0000);
    wb(1'b1, `ITR_ADR_SECFN, 32'hc0);
    settle();
    chk_v("dma overridden", 32'h0, {30'h0, rout[7:6]});
    src.irq <= 16'h0020;
    settle();
    chk_v("out67 irq", 32'h3, {30'h0, rout[7:6]});
    // ring output source selection
    sec.ring <= 1'b1;
    wb(1'b1, `ITR_ADR_MISC, 32'h0);
    settle();
    chk_b("ring card", 1'b1, ring);
    wb(1'b1, `ITR_ADR_MISC, 32'h2);
    settle();
    chk_b("ring pme low", 1'b0, ring);
    pme <= 1'b1;
    settle();
    chk_b("ring pme high", 1'b1, ring);
    // serial stream content
    src <= '0;
    wb(1'b1, `ITR_ADR_SECFN, 32'h0);
    wb(1'b1, `ITR_ADR_DEVCTL, 32'h1);
    ser_count(0);
    src.irq <= 16'h0008;
    ser_count(1);
    chk_b("ser legacy", 1'b1, lc[1] > lc[0]);
    src.irq <= 16'h0;
    src.inta <= 1'b1;
    ser_count(2);
    wb(1'b1, `ITR_ADR_DEVCTL, 32'h0);
    ser_count(3);
    chk_b("ser pci", 1'b1, lc[3] > lc[2]);
    end_sim();
  end
endmodule : test_interrupt_terminal_routing
